// ==== include/gpc_pkg.sv ====
// Shared constants and types of the gated up/down pulse counter.
package gpc_pkg;

    // Register port geometry.
    localparam int GPC_ADDR_W = 4;
    localparam int GPC_DATA_W = 32;

    // Register byte offsets.
    localparam logic [GPC_ADDR_W-1:0] GPC_REG_CTRL   = 4'h0;
    localparam logic [GPC_ADDR_W-1:0] GPC_REG_LOAD   = 4'h4;
    localparam logic [GPC_ADDR_W-1:0] GPC_REG_COUNT  = 4'h8;
    localparam logic [GPC_ADDR_W-1:0] GPC_REG_STATUS = 4'hc;

    // Control register fields.
    localparam int GPC_CTRL_GATE_BIT    = 0;
    localparam int GPC_CTRL_MODE_LSB    = 1;
    localparam int GPC_CTRL_MODE_W      = 2;
    localparam int GPC_CTRL_DIRCONN_BIT = 3;

    // Status register fields.
    localparam int GPC_STAT_UP_BIT       = 0;
    localparam int GPC_STAT_DOWN_BIT     = 1;
    localparam int GPC_STAT_DONE_BIT     = 2;
    localparam int GPC_STAT_OVERRATE_BIT = 3;

    // Count width and reset values.
    localparam int GPC_CNT_W = 16;
    localparam logic [GPC_CNT_W-1:0] GPC_LOAD_RST = 16'h0000;

    // Timing: highest accepted pulse rate and the least edge spacing it implies.
    localparam int GPC_CLK_PERIOD_NS   = 4;
    localparam int GPC_PULSE_MAX_KHZ   = 40;
    localparam int GPC_PULSE_MIN_PER_NS = 1000000 / GPC_PULSE_MAX_KHZ;
    localparam int GPC_MIN_PULSE_CYC   =
        (GPC_PULSE_MIN_PER_NS + GPC_CLK_PERIOD_NS - 1) / GPC_CLK_PERIOD_NS;

    // Counting modes.
    typedef enum logic [GPC_CTRL_MODE_W-1:0] {
        GPC_MODE_CONT,
        GPC_MODE_SINGLE,
        GPC_MODE_PERIODIC
    } gpc_mode_t;

endpackage

// ==== verif/gpc_counter_asserts.sv ====
// Port-level checker of the gated up/down pulse counter and its bind.
`timescale 1ns/1ns
module gpc_counter_chk
    import gpc_pkg::*;
#(
    parameter int CNT_W         = GPC_CNT_W,
    parameter int MIN_PULSE_CYC = GPC_MIN_PULSE_CYC
) (
    // Clock and reset.
    input wire logic                  mclk,
    input wire logic                  sys_rst,
    // Sensor pins.
    input wire logic                  count_pulse_input,
    input wire logic                  count_direction_input,
    // Register port.
    input wire logic [GPC_ADDR_W-1:0] reg_addr,
    input wire logic [GPC_DATA_W-1:0] reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [GPC_DATA_W-1:0] reg_rdata,
    // Status lamps.
    input wire logic                  count_up_led,
    input wire logic                  count_down_led
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside read cycle");
    a_count_upper: assert property (reg_rd && (reg_addr == GPC_REG_COUNT ||
        reg_addr == GPC_REG_LOAD) |=> reg_rdata[31:16] == '0)
        else $error("upper bits of count word not zero");
    a_status_lamps: assert property (reg_rd && reg_addr == GPC_REG_STATUS |=>
        reg_rdata[1:0] == {$past(count_down_led), $past(count_up_led)})
        else $error("status lamp bits differ from lamps");
    a_lamps_excl: assert property (!(count_up_led && count_down_led))
        else $error("both lamps lit");
    a_gate_close: assert property (reg_wr && reg_addr == GPC_REG_CTRL && !reg_wdata[0]
        |=> ##1 !count_up_led && !count_down_led)
        else $error("lamps lit after gate closed");
    a_gate_open_up: assert property (reg_wr && reg_addr == GPC_REG_CTRL &&
        reg_wdata[3:0] == 4'h1 |=> ##1 count_up_led && !count_down_led)
        else $error("up lamp not lit after gate opened");
    a_down_dir: assert property (count_down_led |-> $past(count_direction_input, 3))
        else $error("down lamp lit without direction high");
    a_unmapped_read: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=>
        reg_rdata == '0)
        else $error("unmapped read returned data");
endmodule

bind gpc_counter gpc_counter_chk #(
    .CNT_W         (CNT_W),
    .MIN_PULSE_CYC (MIN_PULSE_CYC)
) u_chk (
    .mclk                  (mclk),
    .sys_rst               (sys_rst),
    .count_pulse_input     (count_pulse_input),
    .count_direction_input (count_direction_input),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .count_up_led          (count_up_led),
    .count_down_led        (count_down_led)
);

// ==== verif/gpc_sensor.sv ====
// Behavioural pulse sensor with a separate direction line.
`timescale 1ns/1ns
module gpc_sensor #(
    parameter int HI = 2
) (
    // Clock.
    input  wire logic mclk,
    // Request from the bench.
    input  wire logic fire,
    input  wire logic dir_req,
    // Sensor pins.
    output logic      pulse,
    output logic      dir = 1'b0
);
    int cnt = 0;

    // A request starts one pulse of HI cycles; direction is set with it and held.
    always @(posedge mclk) begin
        if (fire) begin
            cnt <= HI;
            dir <= dir_req;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign pulse = (cnt != 0);
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench of the gated up/down pulse counter.
`timescale 1ns/1ns
module tb_top;
    import gpc_pkg::*;
    typedef struct packed {
        logic [3:0]  ctrl;
        logic [15:0] load;
        logic        dir;
        logic [3:0]  n;
        logic [15:0] exp;
    } gpc_row_t;
    localparam gpc_row_t ROWS [7] = '{
        '{4'h1, 16'h0000, 1'b0, 4'h3, 16'h0003},
        '{4'h9, 16'h0000, 1'b1, 4'h1, 16'hffff},
        '{4'h1, 16'h0000, 1'b1, 4'h2, 16'h0002},
        '{4'h3, 16'hfffe, 1'b0, 4'h3, 16'h0000},
        '{4'hb, 16'h0001, 1'b1, 4'h3, 16'hffff},
        '{4'h5, 16'hfffe, 1'b0, 4'h3, 16'hffff},
        '{4'hd, 16'h0001, 1'b1, 4'h3, 16'h0000}
    };
    logic                  mclk      = 1'b0;
    logic                  sys_rst   = 1'b1;
    logic                  fire      = 1'b0;
    logic                  dir_req   = 1'b0;
    logic                  pulse_w;
    logic                  dir_w;
    logic [GPC_ADDR_W-1:0] reg_addr  = '0;
    logic [GPC_DATA_W-1:0] reg_wdata = '0;
    logic                  reg_wr    = 1'b0;
    logic                  reg_rd    = 1'b0;
    logic [GPC_DATA_W-1:0] reg_rdata;
    logic                  count_up_led;
    logic                  count_down_led;
    logic [GPC_DATA_W-1:0] v;
    int                    n_errors  = 0;
    int                    checks    = 0;

    gpc_counter #(.MIN_PULSE_CYC(8)) dut (
        .mclk(mclk), .sys_rst(sys_rst),
        .count_pulse_input(pulse_w), .count_direction_input(dir_w),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .count_up_led(count_up_led), .count_down_led(count_down_led)
    );
    gpc_sensor #(.HI(2)) u_sensor (
        .mclk(mclk), .fire(fire), .dir_req(dir_req), .pulse(pulse_w), .dir(dir_w)
    );

    initial begin
        forever #2 mclk = ~mclk;
    end

    task automatic wr(input logic [GPC_ADDR_W-1:0] a, input logic [GPC_DATA_W-1:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [GPC_ADDR_W-1:0] a, output logic [GPC_DATA_W-1:0] d);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // The gap keeps pulses within the legal rate unless a test asks otherwise.
    task automatic pulse(input logic d, input int gap);
        @(posedge mclk);
        fire    <= 1'b1;
        dir_req <= d;
        @(posedge mclk);
        fire    <= 1'b0;
        repeat (gap) @(posedge mclk);
    endtask

    task automatic chk(input logic [GPC_DATA_W-1:0] got, input logic [GPC_DATA_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d, n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 16; a += 2) begin
            rd(a[3:0], v);
            chk(v, '0);
        end
        foreach (ROWS[i]) begin
            wr(GPC_REG_LOAD, {16'h0, ROWS[i].load});
            wr(GPC_REG_CTRL, 32'h4);
            wr(GPC_REG_CTRL, {28'h0, ROWS[i].ctrl});
            repeat (ROWS[i].n) pulse(ROWS[i].dir, 14);
            rd(GPC_REG_COUNT, v);
            chk(v, {16'h0, ROWS[i].exp});
            chk({30'h0, count_down_led, count_up_led}, {30'h0, ROWS[i].ctrl[3] & ROWS[i].dir,
                ~(ROWS[i].ctrl[3] & ROWS[i].dir)});
        end
        wr(GPC_REG_CTRL, 32'h4);
        wr(GPC_REG_CTRL, 32'h9);
        pulse(1'b1, 14);
        pulse(1'b0, 14);
        rd(GPC_REG_COUNT, v);
        chk(v, 32'h0);
        wr(GPC_REG_CTRL, 32'h8);
        pulse(1'b0, 14);
        rd(GPC_REG_COUNT, v);
        chk(v, 32'h0);
        wr(GPC_REG_COUNT, 32'h1234);
        rd(GPC_REG_COUNT, v);
        chk(v, 32'h0);
        wr(GPC_REG_CTRL, 32'h9);
        pulse(1'b0, 14);
        rd(GPC_REG_COUNT, v);
        chk(v, 32'h1);
        rd(GPC_REG_CTRL, v);
        chk(v, 32'h9);
        pulse(1'b0, 4);
        pulse(1'b0, 14);
        rd(GPC_REG_COUNT, v);
        chk(v, 32'h3);
        rd(GPC_REG_STATUS, v);
        chk(v & 32'h8, 32'h8);
        wr(GPC_REG_STATUS, 32'h8);
        rd(GPC_REG_STATUS, v);
        chk(v & 32'h8, 32'h0);
        // A mode chosen behind a closed gate leaves the count alone until the gate opens.
        wr(GPC_REG_LOAD, 32'hffff);
        wr(GPC_REG_CTRL, 32'h2);
        rd(GPC_REG_COUNT, v);
        chk(v, 32'h3);
        wr(GPC_REG_CTRL, 32'h3);
        rd(GPC_REG_COUNT, v);
        chk(v, 32'hffff);
        pulse(1'b0, 14);
        rd(GPC_REG_STATUS, v);
        chk(v, 32'h5);
        // A second reset in mid-run brings back the idle state.
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(GPC_REG_CTRL, v);
        chk(v, 32'h0);
        rd(GPC_REG_COUNT, v);
        chk(v, 32'h0);
        chk({30'h0, count_down_led, count_up_led}, 32'h0);
        final_report();
    end
endmodule

// ==== verilog/gpc_counter.sv ====
// Top of the gated up/down pulse counter: register port, gate, modes and status lamps.
`timescale 1ns/1ns
module gpc_counter
    import gpc_pkg::*;
#(
    parameter int CNT_W         = GPC_CNT_W,
    parameter int MIN_PULSE_CYC = GPC_MIN_PULSE_CYC
) (
    // Clock and reset.
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    // Sensor pins.
    input  wire logic                  count_pulse_input,
    input  wire logic                  count_direction_input,
    // Register port.
    input  wire logic [GPC_ADDR_W-1:0] reg_addr,
    input  wire logic [GPC_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [GPC_DATA_W-1:0] reg_rdata,
    // Status lamps.
    output logic                       count_up_led,
    output logic                       count_down_led
);

    localparam logic [CNT_W-1:0] CNT_MAX  = '1;
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    if (CNT_W < 2 || CNT_W > GPC_CNT_W) begin : g_bad_cnt
        $error("gpc_counter: CNT_W must lie between 2 and the load field width");
    end
    if (MIN_PULSE_CYC < 1) begin : g_bad_rate
        $error("gpc_counter: MIN_PULSE_CYC must be at least 1");
    end

    // Maps the mode field of a control write onto a mode; unused codes mean continuous.
    function automatic gpc_mode_t decode_mode(input logic [GPC_CTRL_MODE_W-1:0] f);
        gpc_mode_t m;
        case (f)
            GPC_CTRL_MODE_W'(GPC_MODE_SINGLE):   m = GPC_MODE_SINGLE;
            GPC_CTRL_MODE_W'(GPC_MODE_PERIODIC): m = GPC_MODE_PERIODIC;
            default:                             m = GPC_MODE_CONT;
        endcase
        return m;
    endfunction

    // Value the count takes when a mode starts.
    function automatic logic [CNT_W-1:0] start_value(input gpc_mode_t m,
                                                     input logic [CNT_W-1:0] ld);
        logic [CNT_W-1:0] v;
        case (m)
            GPC_MODE_SINGLE:   v = ld;
            GPC_MODE_PERIODIC: v = ld;
            default:           v = CNT_ZERO;
        endcase
        return v;
    endfunction

    // Synchronised pins and edge detection.
    logic [1:0]       pins_sync;
    logic             cnt_lvl;
    logic             dir_lvl;
    logic             cnt_prev_q;
    logic             cnt_edge;
    logic             too_fast;

    // Control and status state.
    logic             gate_q;
    gpc_mode_t        mode_q;
    logic             dir_conn_q;
    logic [CNT_W-1:0] load_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             done_q;
    logic             done_set;
    logic             restart_pend_q;
    logic             overrate_q;
    logic             up_led_q;
    logic             down_led_q;
    logic [GPC_DATA_W-1:0] rdata_q;
    logic [GPC_DATA_W-1:0] rdata_d;

    // Decoded register writes.
    logic             wr_ctrl;
    logic             wr_load;
    logic             wr_status;
    gpc_mode_t        new_mode;
    logic             new_gate;
    logic             gate_opening;
    logic             mode_change;
    logic             start_evt;
    logic             count_down;
    logic             pulse_ok;

    gpc_sync #(
        .W (2)
    ) u_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .pin_in   ({count_direction_input, count_pulse_input}),
        .pin_sync (pins_sync)
    );

    assign cnt_lvl = pins_sync[0];
    assign dir_lvl = pins_sync[1];

    // The previous level resets low, the idle level of the count pin, so no false edge.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_prev_q <= 1'b0;
        end else begin
            cnt_prev_q <= cnt_lvl;
        end
    end

    // One count per rising edge; direction is read in the same cycle.
    assign cnt_edge = cnt_lvl & ~cnt_prev_q;

    gpc_rate_mon #(
        .MIN_CYC (MIN_PULSE_CYC)
    ) u_rate (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .edge_in  (cnt_edge),
        .too_fast (too_fast)
    );

    assign wr_ctrl   = reg_wr && (reg_addr == GPC_REG_CTRL);
    assign wr_load   = reg_wr && (reg_addr == GPC_REG_LOAD);
    assign wr_status = reg_wr && (reg_addr == GPC_REG_STATUS);

    assign new_mode = decode_mode(reg_wdata[GPC_CTRL_MODE_LSB +: GPC_CTRL_MODE_W]);
    assign new_gate = reg_wdata[GPC_CTRL_GATE_BIT];

    // Counting begins only through an open gate, so a mode change made while the gate is
    // closed is remembered and applied when the gate next opens; the count holds until then.
    // Opening the gate also restarts a loaded mode, while continuous mode goes on from the
    // held count.
    assign gate_opening = wr_ctrl && new_gate && !gate_q;
    assign mode_change  = wr_ctrl && (new_mode != mode_q);
    assign start_evt    = (mode_change && new_gate) ||
                          (gate_opening && (new_mode != GPC_MODE_CONT || restart_pend_q));

    // A missing direction signal leaves the device counting up.
    // The direction level is the synchronised one of the edge cycle, so a direction change
    // that travels beside the count edge applies to that very edge.
    assign count_down = dir_conn_q && dir_lvl;

    // Pulses pass only through an open gate, and not after a single pass ended.
    assign pulse_ok = cnt_edge && gate_q && !done_q;

    // Gate follows the host's gate bit; writing zero stops counting.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gate_q <= 1'b0;
        end else if (wr_ctrl) begin
            gate_q <= new_gate;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mode_q     <= GPC_MODE_CONT;
            dir_conn_q <= 1'b0;
        end else if (wr_ctrl) begin
            mode_q     <= new_mode;
            dir_conn_q <= reg_wdata[GPC_CTRL_DIRCONN_BIT];
        end
    end

    // A mode chosen behind a closed gate waits for the gate to open.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            restart_pend_q <= 1'b0;
        end else if (start_evt) begin
            restart_pend_q <= 1'b0;
        end else if (mode_change && !new_gate) begin
            restart_pend_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            load_q <= GPC_LOAD_RST[CNT_W-1:0];
        end else if (wr_load) begin
            load_q <= reg_wdata[CNT_W-1:0];
        end
    end

    // Next count: start value, or one step with the limit behaviour of the mode.
    always_comb begin
        count_d  = count_q;
        done_set = 1'b0;
        if (start_evt) begin
            count_d = start_value(new_mode, load_q);
        end else if (pulse_ok) begin
            if (count_down) begin
                if (count_q == CNT_ZERO) begin
                    case (mode_q)
                        GPC_MODE_SINGLE: begin
                            count_d  = CNT_MAX;
                            done_set = 1'b1;
                        end
                        GPC_MODE_PERIODIC: begin
                            count_d = load_q;
                        end
                        default: begin
                            count_d = CNT_MAX;
                        end
                    endcase
                end else begin
                    count_d = CNT_W'(count_q - 1'b1);
                end
            end else begin
                if (count_q == CNT_MAX) begin
                    case (mode_q)
                        GPC_MODE_SINGLE: begin
                            count_d  = CNT_ZERO;
                            done_set = 1'b1;
                        end
                        GPC_MODE_PERIODIC: begin
                            count_d = load_q;
                        end
                        default: begin
                            count_d = CNT_ZERO;
                        end
                    endcase
                end else begin
                    count_d = CNT_W'(count_q + 1'b1);
                end
            end
        end
    end

    // Unsigned count held between zero and all ones.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_q <= CNT_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    // A finished single pass ignores later pulses until the next start.
    // It stays finished across a closed gate; only a start through an open gate clears it.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            done_q <= 1'b0;
        end else if (done_set) begin
            done_q <= 1'b1;
        end else if (start_evt) begin
            done_q <= 1'b0;
        end
    end

    // Sticky flag for edges closer than the rate limit; a new event beats the clear.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            overrate_q <= 1'b0;
        end else if (too_fast) begin
            overrate_q <= 1'b1;
        end else if (wr_status && reg_wdata[GPC_STAT_OVERRATE_BIT]) begin
            overrate_q <= 1'b0;
        end
    end

    // Lamps show the direction the open gate is counting in.
    // With the gate closed neither lamp is lit, whatever the pins do.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            up_led_q   <= 1'b0;
            down_led_q <= 1'b0;
        end else begin
            up_led_q   <= gate_q && !count_down;
            down_led_q <= gate_q && count_down;
        end
    end

    // Read decode; unmapped offsets read zero.
    always_comb begin
        rdata_d = '0;
        case (reg_addr)
            GPC_REG_CTRL: begin
                rdata_d[GPC_CTRL_GATE_BIT]                        = gate_q;
                rdata_d[GPC_CTRL_MODE_LSB +: GPC_CTRL_MODE_W]     = mode_q;
                rdata_d[GPC_CTRL_DIRCONN_BIT]                     = dir_conn_q;
            end
            GPC_REG_LOAD: begin
                rdata_d = GPC_DATA_W'(load_q);
            end
            GPC_REG_COUNT: begin
                rdata_d = GPC_DATA_W'(count_q);
            end
            GPC_REG_STATUS: begin
                rdata_d[GPC_STAT_UP_BIT]       = up_led_q;
                rdata_d[GPC_STAT_DOWN_BIT]     = down_led_q;
                rdata_d[GPC_STAT_DONE_BIT]     = done_q;
                rdata_d[GPC_STAT_OVERRATE_BIT] = overrate_q;
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    // Read data stand for exactly the cycle after the strobe.
    // Nothing is held past that cycle, so a stale word cannot pass for a fresh read.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata      = rdata_q;
    assign count_up_led   = up_led_q;
    assign count_down_led = down_led_q;

endmodule

// ==== verilog/gpc_rate_mon.sv ====
// Flags count edges that arrive closer together than the least legal spacing.
`timescale 1ns/1ns
module gpc_rate_mon
    import gpc_pkg::*;
#(
    parameter int MIN_CYC = GPC_MIN_PULSE_CYC
) (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Edge in, violation pulse out.
    input  wire logic edge_in,
    output logic      too_fast
);

    localparam int GW = $clog2(MIN_CYC + 1);
    localparam logic [GW-1:0] GAP_SAT = GW'(MIN_CYC);

    logic [GW-1:0] gap_q;
    logic          seen_q;
    logic          too_fast_q;

    if (MIN_CYC < 1) begin : g_bad_min
        $error("gpc_rate_mon: MIN_CYC must be at least 1");
    end

    // The gap counter holds the cycles since the last edge, saturating at the limit.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gap_q  <= '0;
            seen_q <= 1'b0;
        end else if (edge_in) begin
            gap_q  <= GW'(1);
            seen_q <= 1'b1;
        end else if (gap_q != GAP_SAT) begin
            gap_q <= gap_q + GW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            too_fast_q <= 1'b0;
        end else begin
            too_fast_q <= edge_in && seen_q && (gap_q < GAP_SAT);
        end
    end

    assign too_fast = too_fast_q;

endmodule

// ==== verilog/gpc_sync.sv ====
// Two-stage synchroniser for a group of asynchronous input pins.
`timescale 1ns/1ns
module gpc_sync
    import gpc_pkg::*;
#(
    parameter int W = 2
) (
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // Raw and synchronised levels.
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    if (W < 1) begin : g_bad_w
        $error("gpc_sync: W must be at least 1");
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_sync = sync_q;

endmodule
